/* hdl/lds_pkg.sv */
package lds_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  // Register byte offsets.
  localparam logic [7:0]  OFS_CFG       = 8'h00;
  localparam logic [7:0]  OFS_CDLY      = 8'h04;
  localparam logic [7:0]  OFS_STAT      = 8'h08;
  localparam logic [7:0]  OFS_IRQ_ST    = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_MSK   = 8'h10;
  localparam logic [7:0]  OFS_DOOR_ALL  = 8'h14;
  localparam logic [7:0]  OFS_DOOR_TAB  = 8'h40;
  localparam logic [5:0]  DOOR_TAB_WORD = 6'h10;

  // Configuration field positions.
  localparam int          CFG_BRAKE_EN  = 0;
  localparam int          CFG_NORMAL    = 1;
  localparam int          CFG_BLOCK120  = 2;
  localparam int          CFG_MIDRESET  = 3;
  localparam int          CFG_FBMODE    = 4;
  localparam int          CFG_DOOR_IND  = 5;
  localparam int          CFG_SLEEP_LSB = 8;
  localparam int          CFG_W         = 12;
  localparam logic [11:0] CFG_RST       = 12'h000;

  // Sleep selector codes.
  localparam logic [3:0]  SLEEP_NEVER   = 4'h0;
  localparam logic [3:0]  SLEEP_LIGHT   = 4'h1;

  // Contactor delay in milliseconds.
  localparam logic [11:0] CDLY_MAX      = 12'hbb8;
  localparam logic [11:0] CDLY_RST      = 12'h1f4;

  // Door types.
  localparam logic [1:0]  DOOR_NONE     = 2'h0;
  localparam logic [1:0]  DOOR_SEMI     = 2'h1;
  localparam logic [1:0]  DOOR_AUTO     = 2'h2;
  localparam logic [5:0]  FLOORS        = 6'h30;

  // Timing.
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          MS_NS         = 1000000;
  localparam int          CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int          BRAKE_CHK_MS  = 500;
  localparam int          MS_PER_MIN    = 60000;
  localparam logic [21:0] TMR_MAX       = 22'h3fffff;

  // Interrupt status bits.
  localparam int          IRQ_POS       = 0;
  localparam int          IRQ_HALT      = 1;
  localparam int          IRQ_BLOCK     = 2;
  localparam int          IRQ_SLEEP_IN  = 3;
  localparam int          IRQ_SLEEP_OUT = 4;
  localparam int          IRQ_BRAKE     = 5;
  localparam int          IRQ_W         = 6;

  typedef enum logic [2:0] {
    ST_PWRUP, ST_RESETDRV, ST_IDLE, ST_RUN, ST_HOLD, ST_HALT, ST_SLEEP, ST_BLOCKED
  } lds_state_t;

endpackage : lds_pkg

/* hdl/lds_supervisor.sv */
// Function
// RQ1: Brake micro-switch feedback is checked only when brake checkback is enabled.
// RQ2: Brake checkback acts only when the brake feedback input is mapped.
// RQ3: Inspection-only mode, the default, refuses normal travel, allows inspection or recall.
// RQ4: After power-up, drive down to the bottom limit to correct position.
// RQ5: Inspection or recall before correction finishes locks the lift to inspection only.
// RQ6: Resume setting: halt while input 120 is off, resume when it returns.
// RQ7: Block setting: block the lift at once when input 120 goes off.
// RQ8: Sleep setting never: sleep mode is never entered.
// RQ9: Cabin-light setting: enter sleep when the cabin light switches off.
// RQ10: Timed setting: sleep after 1 to 60 selectable idle minutes without calls.
// RQ11: Resetting drive runs down at top speed by default until bottom limit cuts.
// RQ12: Middle resetting speed runs the resetting drive at middle speed instead.
// RQ13: Timed mode, VVVF only: hold main contactor after stop for 0-3000 ms.
// RQ14: Feedback mode: hold main contactors while drive-running input is high.
// RQ15: Main contactor release follows brake release, default delay half a second.
// RQ16: Two doors, each semi or fully automatic, enabled per floor independently.
// RQ17: One door setting for all floors or an individual setting per floor.
// RQ18: Each door side per floor is absent, semi-automatic or fully automatic.
// RQ19: Any car or landing call ends sleep mode and resumes service.
module lds_supervisor #(
  parameter int CYC_PER_MS = lds_pkg::CYC_PER_MS
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        bottom_limit_ok,
  input  wire logic        insp_active,
  input  wire logic        recall_active,
  input  wire logic        insp_run_req,
  input  wire logic        normal_run_req,
  input  wire logic        run_dir_up,
  input  wire logic        safety_120_on,
  input  wire logic        cabin_light_on,
  input  wire logic        call_req,
  input  wire logic        brake_fb_mapped,
  input  wire logic        brake_released_fb,
  input  wire logic        drive_running_feedback,
  input  wire logic        vvvf_drive,
  input  wire logic [5:0]  current_floor,
  output logic             drive_up,
  output logic             drive_down,
  output logic             top_speed_level,
  output logic             mid_speed_level,
  output logic             brake_contactor,
  output logic             main_contactor,
  output logic             position_reset,
  output logic             sleep_active,
  output logic             lift_blocked,
  output logic             inspection_lock,
  output logic      [1:0]  door_a_type,
  output logic      [1:0]  door_b_type,
  output logic             irq
);

  typedef struct packed {
    lds_pkg::lds_state_t st;
    logic                insp_mode;
    logic                insp_lock;
    logic                pos_valid;
    logic                cabin_q;
    logic [11:0]         cfg;
    logic [11:0]         cdly;
    logic [3:0]          door_all;
    logic [47:0][3:0]    door_tab;
    logic [17:0]         pre;
    logic [21:0]         tmr;
    logic [9:0]          brk;
    logic [5:0]          irq_st;
    logic [5:0]          irq_msk;
    logic [31:0]         rdata;
    logic                drv_up;
    logic                drv_down;
    logic                spd_top;
    logic                spd_mid;
    logic                brake_on;
    logic                main_on;
    logic                pos_rst;
    logic                sleep;
    logic                blocked;
    logic                irq;
    logic [1:0]          door_a;
    logic [1:0]          door_b;
  } lds_regs_t;

  lds_regs_t   r;
  lds_regs_t   n;
  logic        tick;
  logic        ins;
  logic        flt;
  logic        chk_on;
  logic        moving;
  logic        norm_ok;
  logic        idle_req;
  logic [3:0]  sleep_sel;
  logic [21:0] sleep_ms;
  logic [5:0]  ev;
  logic [5:0]  tab_idx;
  logic [11:0] cdly_w;
  logic        irq_st_out;

  // Idle minutes for each timed sleep code; zero marks a non-timed code.
  function automatic logic [5:0] lds_sleep_min(input logic [3:0] s);
    unique case (s)
      4'h2:    lds_sleep_min = 6'h01;
      4'h3:    lds_sleep_min = 6'h03;
      4'h4:    lds_sleep_min = 6'h05;
      4'h5:    lds_sleep_min = 6'h0a;
      4'h6:    lds_sleep_min = 6'h14;
      4'h7:    lds_sleep_min = 6'h1e;
      4'h8:    lds_sleep_min = 6'h28;
      4'h9:    lds_sleep_min = 6'h32;
      4'ha:    lds_sleep_min = 6'h3c;
      default: lds_sleep_min = 6'h00;
    endcase
  endfunction : lds_sleep_min

  // The unused code 3 is stored as an absent door.
  function automatic logic [1:0] lds_door(input logic [1:0] t);
    lds_door = (t == 2'h3) ? lds_pkg::DOOR_NONE : t;
  endfunction : lds_door

  always_comb begin
    n           = r;
    ev          = '0;
    n.pos_rst   = 1'b0;
    n.rdata     = '0;
    tick        = (r.pre == 18'(CYC_PER_MS - 1));
    n.pre       = tick ? 18'h0 : r.pre + 18'h1;
    if (tick && r.tmr != lds_pkg::TMR_MAX) begin
      n.tmr = r.tmr + 22'h1;
    end
    ins       = insp_active | recall_active;
    sleep_sel = r.cfg[lds_pkg::CFG_SLEEP_LSB +: 4];
    sleep_ms  = 22'(lds_sleep_min(sleep_sel)) * 22'(lds_pkg::MS_PER_MIN);
    norm_ok   = r.cfg[lds_pkg::CFG_NORMAL] & ~r.insp_lock & r.pos_valid & ~ins; // RQ3
    idle_req  = normal_run_req | (ins & insp_run_req) | call_req;
    n.cabin_q = cabin_light_on;
    tab_idx   = reg_addr[7:2] - lds_pkg::DOOR_TAB_WORD;
    cdly_w    = reg_wdata[11:0];
    if (cdly_w > lds_pkg::CDLY_MAX) begin
      cdly_w = lds_pkg::CDLY_MAX;
    end

    // Brake checkback: a command and feedback mismatch held too long is a fault.
    chk_on = r.cfg[lds_pkg::CFG_BRAKE_EN] & brake_fb_mapped; // RQ1 RQ2
    if (!chk_on || brake_released_fb == r.brake_on) begin
      n.brk = '0;
    end else if (tick && r.brk != 10'(lds_pkg::BRAKE_CHK_MS)) begin
      n.brk = r.brk + 10'h1;
    end
    flt = chk_on && (r.brk == 10'(lds_pkg::BRAKE_CHK_MS)) && (r.st != lds_pkg::ST_BLOCKED);

    unique case (r.st)
      lds_pkg::ST_PWRUP: begin
        if (ins) begin
          n.insp_lock = 1'b1; // RQ5
          n.st        = lds_pkg::ST_IDLE;
        end else begin
          n.st = lds_pkg::ST_RESETDRV; // RQ4
        end
      end
      lds_pkg::ST_RESETDRV: begin
        if (ins) begin
          n.insp_lock = 1'b1; // RQ5
          n.st        = lds_pkg::ST_IDLE;
        end else if (!bottom_limit_ok) begin
          n.pos_valid   = 1'b1; // RQ4
          n.pos_rst     = 1'b1;
          ev[lds_pkg::IRQ_POS] = 1'b1;
          n.st          = lds_pkg::ST_IDLE;
        end
      end
      lds_pkg::ST_IDLE: begin
        if (call_req) begin
          n.tmr = '0;
        end
        if (ins && insp_run_req) begin
          n.insp_mode = 1'b1; // RQ3
          n.st        = lds_pkg::ST_RUN;
        end else if (normal_run_req && norm_ok) begin
          n.insp_mode = 1'b0;
          n.st        = lds_pkg::ST_RUN;
        end else if (!idle_req && sleep_sel == lds_pkg::SLEEP_LIGHT &&
                     r.cabin_q && !cabin_light_on) begin
          n.st = lds_pkg::ST_SLEEP; // RQ9
          ev[lds_pkg::IRQ_SLEEP_IN] = 1'b1;
        end else if (!idle_req && sleep_ms != '0 && r.tmr >= sleep_ms) begin
          n.st = lds_pkg::ST_SLEEP; // RQ10
          ev[lds_pkg::IRQ_SLEEP_IN] = 1'b1;
        end
      end
      lds_pkg::ST_RUN: begin
        if (r.insp_mode ? !(ins && insp_run_req) : !(normal_run_req && !ins)) begin
          n.st = lds_pkg::ST_HOLD;
        end
      end
      lds_pkg::ST_HOLD: begin
        // Brake is already dropped here; the main contactor waits.
        if (r.cfg[lds_pkg::CFG_FBMODE]) begin
          if (!drive_running_feedback) begin
            n.st = lds_pkg::ST_IDLE; // RQ14
          end
        end else if (!vvvf_drive || r.tmr >= 22'(r.cdly)) begin
          n.st = lds_pkg::ST_IDLE; // RQ13 RQ15
        end
      end
      lds_pkg::ST_HALT: begin
        if (safety_120_on) begin
          n.st = r.pos_valid ? lds_pkg::ST_IDLE : lds_pkg::ST_PWRUP; // RQ6
        end
      end
      lds_pkg::ST_SLEEP: begin
        if (call_req) begin
          n.st = lds_pkg::ST_IDLE; // RQ19
          ev[lds_pkg::IRQ_SLEEP_OUT] = 1'b1;
        end
      end
      lds_pkg::ST_BLOCKED: begin
        n.st = lds_pkg::ST_BLOCKED;
      end
    endcase

    // Safety input 120 and brake faults override every sequence step except ST_BLOCKED.
    if (flt) begin
      n.st = lds_pkg::ST_BLOCKED;
      ev[lds_pkg::IRQ_BRAKE] = 1'b1;
      ev[lds_pkg::IRQ_BLOCK] = 1'b1;
    end else if (!safety_120_on && r.st != lds_pkg::ST_BLOCKED) begin
      if (r.cfg[lds_pkg::CFG_BLOCK120]) begin
        n.st = lds_pkg::ST_BLOCKED; // RQ7
        ev[lds_pkg::IRQ_BLOCK] = 1'b1;
      end else if (r.st != lds_pkg::ST_HALT) begin
        n.st = lds_pkg::ST_HALT; // RQ6
        ev[lds_pkg::IRQ_HALT] = 1'b1;
      end
    end
    if (n.st != r.st) begin
      n.tmr = '0;
      n.pre = '0;
    end

    // Drive outputs follow the next state so they line up with it.
    moving     = (n.st == lds_pkg::ST_RESETDRV) || (n.st == lds_pkg::ST_RUN);
    n.drv_down = (n.st == lds_pkg::ST_RESETDRV) || (n.st == lds_pkg::ST_RUN && !run_dir_up);
    n.drv_up   = (n.st == lds_pkg::ST_RUN) && run_dir_up;
    n.spd_top  = ((n.st == lds_pkg::ST_RESETDRV) && !r.cfg[lds_pkg::CFG_MIDRESET]) || // RQ11
                 ((n.st == lds_pkg::ST_RUN) && !n.insp_mode);
    n.spd_mid  = ((n.st == lds_pkg::ST_RESETDRV) && r.cfg[lds_pkg::CFG_MIDRESET]) || // RQ12
                 ((n.st == lds_pkg::ST_RUN) && n.insp_mode);
    n.brake_on = moving;
    n.main_on  = moving || (n.st == lds_pkg::ST_HOLD); // RQ13 RQ14
    n.sleep    = (n.st == lds_pkg::ST_SLEEP); // RQ8
    n.blocked  = (n.st == lds_pkg::ST_BLOCKED);

    // Register writes.
    if (reg_wr) begin
      if (reg_addr == lds_pkg::OFS_CFG) begin
        n.cfg = reg_wdata[11:0];
      end else if (reg_addr == lds_pkg::OFS_CDLY) begin
        n.cdly = cdly_w;
      end else if (reg_addr == lds_pkg::OFS_IRQ_MSK) begin
        n.irq_msk = reg_wdata[5:0];
      end else if (reg_addr == lds_pkg::OFS_DOOR_ALL) begin
        n.door_all = {lds_door(reg_wdata[3:2]), lds_door(reg_wdata[1:0])}; // RQ18
      end else if (reg_addr >= lds_pkg::OFS_DOOR_TAB) begin
        n.door_tab[tab_idx] = {lds_door(reg_wdata[3:2]), lds_door(reg_wdata[1:0])}; // RQ16
      end
    end
    // A new event wins over a write-one clear in the same cycle.
    n.irq_st = (r.irq_st & ~((reg_wr && reg_addr == lds_pkg::OFS_IRQ_ST) ?
                reg_wdata[5:0] : 6'h00)) | ev;
    n.irq    = |(n.irq_st & n.irq_msk);

    // Door types for the car's present floor.
    if (current_floor >= lds_pkg::FLOORS) begin
      n.door_a = lds_pkg::DOOR_NONE;
      n.door_b = lds_pkg::DOOR_NONE;
    end else if (r.cfg[lds_pkg::CFG_DOOR_IND]) begin
      n.door_a = r.door_tab[current_floor][1:0]; // RQ17
      n.door_b = r.door_tab[current_floor][3:2];
    end else begin
      n.door_a = r.door_all[1:0]; // RQ17
      n.door_b = r.door_all[3:2];
    end

    // Read data stand for exactly the cycle after the strobe.
    if (reg_rd) begin
      if (reg_addr == lds_pkg::OFS_CFG) begin
        n.rdata = {20'h00000, r.cfg};
      end else if (reg_addr == lds_pkg::OFS_CDLY) begin
        n.rdata = {20'h00000, r.cdly};
      end else if (reg_addr == lds_pkg::OFS_STAT) begin
        n.rdata = {24'h000000, r.blocked, r.sleep, r.insp_lock, r.pos_valid, 1'b0, r.st};
      end else if (reg_addr == lds_pkg::OFS_IRQ_ST) begin
        n.rdata = {26'h0000000, r.irq_st};
      end else if (reg_addr == lds_pkg::OFS_IRQ_MSK) begin
        n.rdata = {26'h0000000, r.irq_msk};
      end else if (reg_addr == lds_pkg::OFS_DOOR_ALL) begin
        n.rdata = {28'h0000000, r.door_all};
      end else if (reg_addr >= lds_pkg::OFS_DOOR_TAB) begin
        n.rdata = {28'h0000000, r.door_tab[tab_idx]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r      <= '0;
      r.cfg  <= lds_pkg::CFG_RST;
      r.cdly <= lds_pkg::CDLY_RST;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata       = r.rdata;
  assign drive_up        = r.drv_up;
  assign drive_down      = r.drv_down;
  assign top_speed_level = r.spd_top;
  assign mid_speed_level = r.spd_mid;
  assign brake_contactor = r.brake_on;
  assign main_contactor  = r.main_on;
  assign position_reset  = r.pos_rst;
  assign sleep_active    = r.sleep;
  assign lift_blocked    = r.blocked;
  assign inspection_lock = r.insp_lock;
  assign door_a_type     = r.door_a;
  assign door_b_type     = r.door_b;
  assign irq             = r.irq;

  a_brake_chk_off: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ1 RQ2
    (!r.cfg[lds_pkg::CFG_BRAKE_EN] || !brake_fb_mapped) |-> !ev[lds_pkg::IRQ_BRAKE])
    else $error("brake fault raised with checkback off or unmapped");

  a_normal_refused: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ3
    $rose(r.st == lds_pkg::ST_RUN && !r.insp_mode) |->
      $past(r.cfg[lds_pkg::CFG_NORMAL] && !r.insp_lock && r.pos_valid))
    else $error("normal travel started while refused");

  a_reset_drive_out: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ4 RQ11 RQ12
    (r.st == lds_pkg::ST_RESETDRV) |-> drive_down && !drive_up &&
      (top_speed_level == !$past(r.cfg[lds_pkg::CFG_MIDRESET])) &&
      (mid_speed_level == $past(r.cfg[lds_pkg::CFG_MIDRESET])))
    else $error("resetting drive outputs wrong");

  a_pos_corrected: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ4
    (r.st == lds_pkg::ST_RESETDRV && !bottom_limit_ok && !ins && safety_120_on && !flt) |=>
      position_reset && r.pos_valid && !drive_down ##1 !position_reset)
    else $error("position correction not completed at bottom limit");

  a_insp_lock: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ5
    (r.st inside {lds_pkg::ST_PWRUP, lds_pkg::ST_RESETDRV} && ins) |=> inspection_lock)
    else $error("inspection lock not taken before correction");

  a_resume_120: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ6
    (r.st == lds_pkg::ST_HALT && safety_120_on && r.pos_valid && !flt) |=>
      (r.st == lds_pkg::ST_IDLE) && !brake_contactor)
    else $error("no resume after input 120 returned");

  a_block_120: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ7
    (r.cfg[lds_pkg::CFG_BLOCK120] && !safety_120_on) |=> (lift_blocked && !main_contactor) [*2])
    else $error("lift not blocked when input 120 went off");

  a_sleep_never: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ8
    (!sleep_active && sleep_sel == lds_pkg::SLEEP_NEVER) |=> !sleep_active)
    else $error("sleep entered with sleep setting never");

  a_sleep_light: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ9
    (r.st == lds_pkg::ST_IDLE && sleep_sel == lds_pkg::SLEEP_LIGHT && $fell(cabin_light_on) &&
     !idle_req && safety_120_on && !flt) |=> sleep_active)
    else $error("no sleep when cabin light went off");

  a_sleep_wake: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ19
    (sleep_active && call_req && safety_120_on && !flt) |=> !sleep_active && irq_st_out)
    else $error("call did not end sleep");

  assign irq_st_out = r.irq_st[lds_pkg::IRQ_SLEEP_OUT];

  a_fb_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ14
    (r.st == lds_pkg::ST_HOLD && r.cfg[lds_pkg::CFG_FBMODE] && drive_running_feedback &&
     safety_120_on && !flt) |=> main_contactor && !brake_contactor)
    else $error("main contactor dropped while drive running");

  a_door_shared: assert property (@(posedge core_clk) disable iff (!reset_n) // RQ16 RQ17
    (!r.cfg[lds_pkg::CFG_DOOR_IND] && current_floor < lds_pkg::FLOORS) |=>
      ({door_b_type, door_a_type} == $past(r.door_all)))
    else $error("shared door setting not applied");

endmodule : lds_supervisor

/* dv/lds_shaft_model.sv */
module lds_shaft_model #(
  parameter int LAG  = 7,
  parameter int POS0 = 40
) (
  input  wire logic core_clk,
  input  wire logic drive_up,
  input  wire logic drive_down,
  input  wire logic brake_contactor,
  input  wire logic main_contactor,
  input  wire logic brake_stuck,
  output logic      bottom_limit_ok,
  output logic      brake_released_fb,
  output logic      drive_running_feedback
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos = POS0;
  int lag = LAG;
  // The car moves one step per cycle while a direction is commanded.
  always @(posedge core_clk) begin
    if (drive_up) begin
      pos <= pos + 1;
    end else if (drive_down && pos > 0) begin
      pos <= pos - 1;
    end
    lag <= brake_contactor ? 0 : (lag < LAG ? lag + 1 : lag);
  end
  assign bottom_limit_ok = pos > 0;
  // A stuck micro-switch reports a released brake whatever the contactor does.
  assign brake_released_fb = brake_stuck | brake_contactor;
  // The drive ramps down for a few cycles after the brake contactor drops.
  assign drive_running_feedback = main_contactor && (brake_contactor || lag < LAG);
endmodule : lds_shaft_model

/* dv/lift_drive_supervisor_bench.sv */
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
`define WAITC(c, n) begin wk = 0; while (!(c) && wk < (n)) begin @(posedge core_clk); #1; \
  wk++; end if (!(c)) begin n_fail++; close_out(); end end
module lift_drive_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        insp_active = 1'b0, recall_active = 1'b0, insp_run_req = 1'b0;
  logic        normal_run_req = 1'b0, run_dir_up = 1'b1, safety_120_on = 1'b1;
  logic        cabin_light_on = 1'b1, call_req = 1'b0, brake_fb_mapped = 1'b0;
  logic        vvvf_drive = 1'b1, brake_stuck = 1'b0;
  logic [5:0]  current_floor = 6'h00;
  logic        bottom_limit_ok, brake_released_fb, drive_running_feedback;
  logic        drive_up, drive_down, top_speed_level, mid_speed_level;
  logic        brake_contactor, main_contactor, position_reset, sleep_active;
  logic        lift_blocked, inspection_lock, irq;
  logic [1:0]  door_a_type, door_b_type;
  logic [11:0] cfg = 12'h000;
  logic [31:0] rnd = 32'h15864ac5;
  int          n_fail = 0, compares = 0, wk, n, dly;
  int          shadow [int];

  lds_supervisor #(.CYC_PER_MS(1)) dut (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bottom_limit_ok, .insp_active, .recall_active, .insp_run_req, .normal_run_req,
    .run_dir_up, .safety_120_on, .cabin_light_on, .call_req, .brake_fb_mapped,
    .brake_released_fb, .drive_running_feedback, .vvvf_drive, .current_floor,
    .drive_up, .drive_down, .top_speed_level, .mid_speed_level, .brake_contactor,
    .main_contactor, .position_reset, .sleep_active, .lift_blocked, .inspection_lock,
    .door_a_type, .door_b_type, .irq
  );
  lds_shaft_model #(.LAG(7)) shaft (
    .core_clk, .drive_up, .drive_down, .brake_contactor, .main_contactor, .brake_stuck,
    .bottom_limit_ok, .brake_released_fb, .drive_running_feedback
  );

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Register model: delay saturates, door code 3 reads back as none.
  function automatic int model(int a, int v);
    int lo = (v & 3) == 3 ? 0 : v & 3;
    int hi = (v & 'hc) == 'hc ? 0 : v & 'hc;
    if (a == int'(lds_pkg::OFS_CDLY)) return v > 3000 ? 3000 : v;
    if (a == int'(lds_pkg::OFS_CFG)) return v & 'hf3f;
    return lo | hi;
  endfunction : model

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a != lds_pkg::OFS_IRQ_ST && a != lds_pkg::OFS_IRQ_MSK) shadow[a] = model(a, v);
  endtask : wr

  task automatic rdc(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rdc

  task automatic setcfg(logic [11:0] c);
    cfg = c;
    wr(lds_pkg::OFS_CFG, {20'h0, c});
  endtask : setcfg

  task automatic door_chk();
    int e;
    repeat (2) @(posedge core_clk);
    #1;
    e = current_floor >= 48 ? 0 : shadow[cfg[5] ? 64 + 4 * current_floor : 20];
    `CHK(door_a_type, e[1:0])
    `CHK(door_b_type, e[3:2])
  endtask : door_chk

  // Runs the car up briefly and counts cycles the main contactor outlasts the brake.
  task automatic run_stop(output int cnt);
    @(posedge core_clk);
    normal_run_req <= 1'b1;
    `WAITC(drive_up && top_speed_level && brake_contactor && main_contactor, 4)
    repeat (3) @(posedge core_clk);
    normal_run_req <= 1'b0;
    `WAITC(!brake_contactor, 4)
    cnt = 0;
    while (main_contactor && cnt < 4000) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
  endtask : run_stop

  task automatic do_reset();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    cfg = 12'h000;
    shadow[lds_pkg::OFS_CFG] = 0;
    shadow[lds_pkg::OFS_CDLY] = 500;
  endtask : do_reset

  initial begin
    do_reset();
    `WAITC(drive_down, 8)
    `CHK({top_speed_level, mid_speed_level}, 2'b10)
    @(posedge core_clk);
    safety_120_on <= 1'b0;
    `WAITC(!drive_down, 4)
    setcfg(12'h008);
    @(posedge core_clk);
    safety_120_on <= 1'b1;
    `WAITC(drive_down, 8)
    `CHK({top_speed_level, mid_speed_level}, 2'b01)
    `WAITC(position_reset, 100)
    @(posedge core_clk);
    #1;
    `CHK({position_reset, drive_down}, 2'b00)
    rdc(lds_pkg::OFS_CDLY, 32'd500);
    rdc(lds_pkg::OFS_IRQ_ST, 32'h3);
    rdc(8'h3c, 32'h0);
    wr(lds_pkg::OFS_IRQ_MSK, 32'h1);
    `WAITC(irq, 3)
    wr(lds_pkg::OFS_IRQ_ST, 32'h3);
    `WAITC(!irq, 3)
    rdc(lds_pkg::OFS_IRQ_ST, 32'h0);
    $display("Test reset drive finished");
    @(posedge core_clk);
    normal_run_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK(drive_up, 1'b0)
    normal_run_req <= 1'b0;
    insp_active <= 1'b1;
    insp_run_req <= 1'b1;
    `WAITC(drive_up && mid_speed_level, 4)
    insp_active <= 1'b0;
    insp_run_req <= 1'b0;
    `WAITC(!main_contactor, 600)
    setcfg(12'h002);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr(lds_pkg::OFS_CDLY, {20'h0, rnd[11:0]});
      rdc(lds_pkg::OFS_CDLY, shadow[lds_pkg::OFS_CDLY]);
      dly = rnd[20:16];
      wr(lds_pkg::OFS_CDLY, dly);
      run_stop(n);
      `CHK(n >= dly && n <= dly + 2, 1'b1)
    end
    vvvf_drive <= 1'b0;
    run_stop(n);
    `CHK(n <= 2, 1'b1)
    vvvf_drive <= 1'b1;
    wr(lds_pkg::OFS_CDLY, 32'd100);
    setcfg(12'h012);
    run_stop(n);
    `CHK(n >= 6 && n <= 9, 1'b1)
    $display("Test contactor finished");
    for (int i = 0; i < 4; i++) begin
      wr(lds_pkg::OFS_DOOR_ALL, i | ((3 - i) << 2));
      door_chk();
    end
    setcfg(12'h022);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(lds_pkg::OFS_DOOR_TAB + 8'(4 * (rnd[5:0] % 48)), {28'h0, rnd[11:8]});
      current_floor <= i == 3 ? 6'h30 : rnd[5:0] % 48;
      door_chk();
    end
    setcfg(12'h002);
    @(posedge core_clk);
    cabin_light_on <= 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    `CHK(sleep_active, 1'b0)
    cabin_light_on <= 1'b1;
    setcfg(12'h102);
    @(posedge core_clk);
    cabin_light_on <= 1'b0;
    `WAITC(sleep_active, 4)
    call_req <= 1'b1;
    `WAITC(!sleep_active, 3)
    call_req <= 1'b0;
    setcfg(12'h202);
    repeat (59900) @(posedge core_clk);
    #1;
    `CHK(sleep_active, 1'b0)
    `WAITC(sleep_active, 300)
    call_req <= 1'b1;
    `WAITC(!sleep_active, 3)
    call_req <= 1'b0;
    $display("Test sleep finished");
    normal_run_req <= 1'b1;
    `WAITC(drive_up, 4)
    safety_120_on <= 1'b0;
    `WAITC(!drive_up && !brake_contactor, 3)
    normal_run_req <= 1'b0;
    rdc(lds_pkg::OFS_STAT, 32'h15);
    safety_120_on <= 1'b1;
    rdc(lds_pkg::OFS_STAT, 32'h12);
    setcfg(12'h006);
    safety_120_on <= 1'b0;
    `WAITC(lift_blocked, 3)
    safety_120_on <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    `CHK(lift_blocked, 1'b1)
    $display("Test safety input finished");
    do_reset();
    `WAITC(drive_down, 8)
    recall_active <= 1'b1;
    `WAITC(inspection_lock, 4)
    recall_active <= 1'b0;
    repeat (100) @(posedge core_clk);
    setcfg(12'h003);
    normal_run_req <= 1'b1;
    brake_stuck <= 1'b1;
    repeat (600) @(posedge core_clk);
    #1;
    `CHK({drive_up, lift_blocked}, 2'b00)
    normal_run_req <= 1'b0;
    brake_fb_mapped <= 1'b1;
    setcfg(12'h002);
    repeat (600) @(posedge core_clk);
    #1;
    `CHK(lift_blocked, 1'b0)
    setcfg(12'h003);
    repeat (480) @(posedge core_clk);
    #1;
    `CHK(lift_blocked, 1'b0)
    `WAITC(lift_blocked, 40)
    $display("Test lock and brake finished");
    close_out();
  end
endmodule : lift_drive_supervisor_bench
